/* File: hw/gdc_pkg.sv */
package gdc_pkg;
    localparam int CLK_NS = 20;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] AMP_OFS  = 8'h04;
    localparam logic [7:0] TIME_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam logic [7:0] CLR_OFS  = 8'h10;
    // control fields
    localparam int TCP_BIT  = 0;
    localparam int DTM_BIT  = 1;
    localparam int DT6_LSB  = 2;
    localparam int SIX_BIT  = 4;
    localparam int SS_BIT   = 5;
    localparam int WARN_BIT = 6;
    localparam logic [6:0] CTRL_RST = 7'h10;
    // amplifier fields
    localparam int AMP_EN_BIT = 0;
    localparam int GAIN_LSB   = 1;
    localparam int HALF_BIT   = 5;
    localparam logic [3:0] GAIN_MAX = 4'h8;
    localparam logic [5:0] AMP_RST  = 6'h00;
    // timing fields
    localparam int HOLD_LSB = 0;
    localparam int DEAD_LSB = 8;
    localparam int SDI_LSB  = 16;
    localparam logic [19:0] TIME_RST = 20'h0050a;
    // status fields
    localparam int ST_OVUV = 0;
    localparam int ST_STP  = 1;
    localparam int ST_UVW  = 2;
    localparam int ST_UV   = 3;
    localparam int ST_RDY  = 4;
    localparam int ST_SD   = 5;
    localparam int CLR_BIT = 0;
    // times in ns and their cycle counts
    localparam int SD1_NS        = 1000;
    localparam int SD2_NS        = 4000;
    localparam int UVW_DG_NS     = 2000;
    localparam int UV_DG_NS      = 2000;
    localparam int AMP_SETTLE_NS = 100000;
    localparam int SD1_CYC    = SD1_NS / CLK_NS;
    localparam int SD2_CYC    = SD2_NS / CLK_NS;
    localparam int UVW_DG_CYC = (UVW_DG_NS + CLK_NS - 1) / CLK_NS;
    localparam int UV_DG_CYC  = (UV_DG_NS + CLK_NS - 1) / CLK_NS;
    localparam int AMP_SETTLE_CYC = (AMP_SETTLE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        SD_RUN  = 2'b00,
        SD_INIT = 2'b01,
        SD_PROG = 2'b10,
        SD_SEMI = 2'b11
    } sd_state_t;

    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
        logic [2:0] pd_hi;
        logic [2:0] pd_lo;
    } gate_bus_t;

    // field order matches the register bits: en bit 0, half_ref bit 5
    typedef struct packed {
        logic       half_ref;
        logic [3:0] gain;
        logic       en;
    } amp_cfg_t;

    typedef struct packed {
        logic       gh;
        logic       gl;
        logic [7:0] off_cnt;
        logic [7:0] hold_h;
        logic [7:0] hold_l;
        logic       stp;
    } phase_st_t;

    typedef struct packed {
        logic [9:0]  s1;
        logic [9:0]  s2;
        logic [6:0]  ctrl;
        amp_cfg_t    amp;
        logic [19:0] tim;
        logic        ovuv;
        logic        stp;
        logic        uvw;
        logic        uv;
        logic [7:0]  uvw_cnt;
        logic [7:0]  uv_cnt;
        sd_state_t   sd;
        logic [8:0]  sd_cnt;
        logic [12:0] amp_cnt;
        logic        amp_rdy;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } core_st_t;
endpackage

/* File: hw/half_bridge.sv */
`timescale 1ns/1ns
module half_bridge
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // synchronised commands
    input  wire logic       hi_in,
    input  wire logic       lo_in,
    input  wire logic       kill,
    // configuration
    input  wire logic       six_mode,
    input  wire logic       auto_dead,
    input  wire logic [7:0] dead_cyc,
    input  wire logic [7:0] hold_cyc,
    // gate commands
    output logic            gh,
    output logic            gl,
    output logic            pd_h,
    output logic            pd_l,
    output logic            stp
);
    gdc_pkg::phase_st_t s_q;
    gdc_pkg::phase_st_t s_d;
    logic               clash;
    logic               insert;
    logic               ok;

    always_comb
    begin
        s_d    = s_q;
        clash  = hi_in & lo_in;
        insert = !six_mode | auto_dead; // R6 R7
        ok     = !insert | (s_q.off_cnt >= dead_cyc); // R6 R7
        s_d.stp = six_mode & clash; // R5
        if (kill | clash)
        begin
            s_d.gh = 1'b0;
            s_d.gl = 1'b0;
        end
        else
        begin
            s_d.gh = hi_in & (s_q.gh | (!s_q.gl & ok));
            s_d.gl = lo_in & (s_q.gl | (!s_q.gh & ok));
        end
        if (s_q.gh | s_q.gl)
            s_d.off_cnt = 8'h00;
        else if (s_q.off_cnt != 8'hff)
            s_d.off_cnt = s_q.off_cnt + 8'h01;
        // opposite gate strong pull-down after each edge
        if (s_d.gh != s_q.gh)
            s_d.hold_l = hold_cyc; // R4
        else if (s_q.hold_l != 8'h00)
            s_d.hold_l = s_q.hold_l - 8'h01;
        if (s_d.gl != s_q.gl)
            s_d.hold_h = hold_cyc; // R4
        else if (s_q.hold_h != 8'h00)
            s_d.hold_h = s_q.hold_h - 8'h01;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign gh   = s_q.gh;
    assign gl   = s_q.gl;
    assign pd_h = s_q.hold_h != 8'h00;
    assign pd_l = s_q.hold_l != 8'h00;
    assign stp  = s_q.stp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_shoot_both_low: assert property (six_mode && hi_in && lo_in |=> !gh && !gl) // R5
        else $error("both gates not low on input clash");
    a_no_overlap: assert property (!(gh && gl)) // R7
        else $error("both gates of one half-bridge on");
    a_dead_gap: assert property ($rose(gh) && $past(insert) |-> // R6
        $past(s_q.off_cnt) >= $past(dead_cyc))
        else $error("high gate on before dead time");
    a_hold_pulse: assert property ($changed(gh) && $past(hold_cyc) != 8'h00 |-> pd_l) // R4
        else $error("no strong pull-down after high gate edge");
endmodule

/* File: hw/gate_drive_ctrl.sv */
// Overview of operation
// (R1) bootstrap charging only while low input low
// (R2) always-on bit keeps bootstrap charging enabled
// (R3) overdrive undervolt flag set at reset, cleared
// (R4) strong pull-down on opposite gate after switching
// (R5) six-input clash: both gates low, flag
// (R6) six-input auto mode inserts short dead time
// (R7) other modes always insert dead time
// (R8) amplifier gain: nine settings, 5 to 40
// (R9) amplifier offset half or eighth reference
// (R10) amplifier disabled after reset until enabled
// (R11) controller waits 100 us after amplifier enable
// (R12) fault or disable input shuts gates down
// (R13) disable pin overrides gates bypassing logic
// (R14) shutdown: initial, programmed, then semi-active
// (R15) deglitched warning handled per warning mode
// (R16) lockout disables gates, pump, fault low
// (R17) lockout stays latched until clear command
// (R18) sleep engages low-side semi-active pull-down
// (R19) controller sets soft-start disable after power-up
// (R20) flags latched until clear; fault pin follows
`timescale 1ns/1ns
module gate_drive_ctrl
#(
    parameter int AMP_SETTLE_CYC = gdc_pkg::AMP_SETTLE_CYC
)
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // pins from the controller and monitors
    input  wire logic [2:0]        high_side_pwm_in,
    input  wire logic [2:0]        low_side_pwm_in,
    input  wire logic              hardware_disable_in,
    input  wire logic              supply_below_warn,
    input  wire logic              supply_below_lockout,
    input  wire logic              sleep_in,
    // gate driver
    output gdc_pkg::gate_bus_t     gate,
    output logic [2:0]             bootstrap_charge_en,
    output logic [2:0]             semi_pd_low,
    output logic                   semi_pd_high,
    output gdc_pkg::sd_state_t     shutdown_stage,
    output logic [3:0]             shutdown_sink_current,
    output logic                   charge_pump_en,
    output logic                   gate_supply_softstart_disable,
    // current sense amplifier
    output gdc_pkg::amp_cfg_t      current_sense_amp,
    output logic                   amp_ready,
    // fault pin
    output logic                   fault_out_n
);
    gdc_pkg::core_st_t st_q;
    gdc_pkg::core_st_t st_d;
    logic [2:0]        ph_hi;
    logic [2:0]        ph_lo;
    logic [2:0]        ph_pdh;
    logic [2:0]        ph_pdl;
    logic [2:0]        ph_stp;
    logic              shut;
    logic              kill;
    logic              wr;
    logic              clr;
    logic [31:0]       merged;
    logic [31:0]       old;
    logic [31:0]       mask;
    logic [31:0]       rd;
    logic              rd_ok;
    logic [2:0]        lo_s;

    assign lo_s = st_q.s2[5:3];
    assign shut = st_q.s2[6] | st_q.uv | st_q.ovuv; // R12 R16
    assign kill = shut | (st_q.sd != gdc_pkg::SD_RUN);

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : phase
            half_bridge u_hb
            (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .hi_in     (st_q.s2[g]),
                .lo_in     (st_q.s2[3 + g]),
                .kill      (kill),
                .six_mode  (st_q.ctrl[gdc_pkg::SIX_BIT]),
                .auto_dead (st_q.ctrl[gdc_pkg::DTM_BIT +: 3] == 3'b000),
                .dead_cyc  (st_q.tim[gdc_pkg::DEAD_LSB +: 8]),
                .hold_cyc  (st_q.tim[gdc_pkg::HOLD_LSB +: 8]),
                .gh        (ph_hi[g]),
                .gl        (ph_lo[g]),
                .pd_h      (ph_pdh[g]),
                .pd_l      (ph_pdl[g]),
                .stp       (ph_stp[g])
            );
        end
    endgenerate

    // register read mux
    always_comb
    begin
        rd    = 32'h0000_0000;
        rd_ok = 1'b1;
        case (araddr)
            gdc_pkg::CTRL_OFS: rd[6:0]  = st_q.ctrl;
            gdc_pkg::AMP_OFS:  rd[5:0]  = st_q.amp;
            gdc_pkg::TIME_OFS: rd[19:0] = st_q.tim;
            gdc_pkg::STAT_OFS:
            begin
                rd[gdc_pkg::ST_OVUV]   = st_q.ovuv;
                rd[gdc_pkg::ST_STP]    = st_q.stp;
                rd[gdc_pkg::ST_UVW]    = st_q.uvw;
                rd[gdc_pkg::ST_UV]     = st_q.uv;
                rd[gdc_pkg::ST_RDY]    = st_q.amp_rdy;
                rd[gdc_pkg::ST_SD +: 2] = st_q.sd;
            end
            gdc_pkg::CLR_OFS:  rd = 32'h0000_0000;
            default:           rd_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        st_d = st_q;
        st_d.s1 = {sleep_in, supply_below_lockout, supply_below_warn,
                   hardware_disable_in, low_side_pwm_in, high_side_pwm_in};
        st_d.s2 = st_q.s1;
        // write channel
        if (awvalid && !st_q.aw_got)
        begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = awaddr;
        end
        if (wvalid && !st_q.w_got)
        begin
            st_d.w_got = 1'b1;
            st_d.wdata = wdata;
            st_d.wstrb = wstrb;
        end
        if (st_q.bvalid && bready)
            st_d.bvalid = 1'b0;
        wr   = st_q.aw_got & st_q.w_got & !st_q.bvalid;
        mask = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}},
                {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
        case (st_q.awaddr)
            gdc_pkg::CTRL_OFS: old = {25'h0, st_q.ctrl};
            gdc_pkg::AMP_OFS:  old = {26'h0, st_q.amp};
            gdc_pkg::TIME_OFS: old = {12'h0, st_q.tim};
            default:           old = 32'h0000_0000;
        endcase
        merged = (old & ~mask) | (st_q.wdata & mask);
        clr    = 1'b0;
        if (wr)
        begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = 2'b00;
            case (st_q.awaddr)
                gdc_pkg::CTRL_OFS: st_d.ctrl = merged[6:0];
                gdc_pkg::AMP_OFS:
                begin
                    st_d.amp = merged[5:0]; // R8 R9 R10
                    if (merged[gdc_pkg::GAIN_LSB +: 4] > gdc_pkg::GAIN_MAX)
                        st_d.amp.gain = gdc_pkg::GAIN_MAX; // R8
                end
                gdc_pkg::TIME_OFS: st_d.tim = merged[19:0];
                gdc_pkg::CLR_OFS:  clr = merged[gdc_pkg::CLR_BIT]; // R3 R17
                gdc_pkg::STAT_OFS: st_d.bresp = 2'b00;
                default:           st_d.bresp = 2'b10;
            endcase
        end
        // read channel
        if (st_q.rvalid && rready)
            st_d.rvalid = 1'b0;
        if (arvalid && !st_q.rvalid)
        begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = rd;
            st_d.rresp  = rd_ok ? 2'b00 : 2'b10;
        end
        // deglitch of the supply monitors
        if (!st_q.s2[7])
            st_d.uvw_cnt = 8'h00;
        else if (st_q.uvw_cnt != 8'(gdc_pkg::UVW_DG_CYC))
            st_d.uvw_cnt = st_q.uvw_cnt + 8'h01;
        if (!st_q.s2[8])
            st_d.uv_cnt = 8'h00;
        else if (st_q.uv_cnt != 8'(gdc_pkg::UV_DG_CYC))
            st_d.uv_cnt = st_q.uv_cnt + 8'h01;
        // latched flags, a new event beats the clear
        st_d.ovuv = st_q.ovuv & !clr; // R3
        st_d.stp  = (|ph_stp) | (st_q.stp & !clr); // R5 R20
        st_d.uvw  = (st_q.s2[7] && st_q.uvw_cnt == 8'(gdc_pkg::UVW_DG_CYC))
                    | (st_q.uvw & !clr); // R15 R20
        st_d.uv   = (st_q.s2[8] && st_q.uv_cnt == 8'(gdc_pkg::UV_DG_CYC))
                    | (st_q.uv & !clr); // R16 R17
        // shutdown current staging
        case (st_q.sd)
            gdc_pkg::SD_RUN:
            begin
                st_d.sd_cnt = 9'h000;
                if (shut)
                    st_d.sd = gdc_pkg::SD_INIT; // R12 R14
            end
            gdc_pkg::SD_INIT:
            begin
                st_d.sd_cnt = st_q.sd_cnt + 9'h001;
                if (st_q.sd_cnt == 9'(gdc_pkg::SD1_CYC - 1))
                begin
                    st_d.sd     = gdc_pkg::SD_PROG; // R14
                    st_d.sd_cnt = 9'h000;
                end
            end
            gdc_pkg::SD_PROG:
            begin
                st_d.sd_cnt = st_q.sd_cnt + 9'h001;
                if (st_q.sd_cnt == 9'(gdc_pkg::SD2_CYC - 1))
                begin
                    st_d.sd     = gdc_pkg::SD_SEMI; // R14
                    st_d.sd_cnt = 9'h000;
                end
            end
            gdc_pkg::SD_SEMI:
            begin
                if (!shut)
                    st_d.sd = gdc_pkg::SD_RUN;
            end
            default: st_d.sd = gdc_pkg::SD_SEMI;
        endcase
        // amplifier settling status
        if (!st_q.amp.en)
        begin
            st_d.amp_cnt = 13'h0000;
            st_d.amp_rdy = 1'b0;
        end
        else if (st_q.amp_cnt == 13'(AMP_SETTLE_CYC))
            st_d.amp_rdy = 1'b1; // R11
        else
            st_d.amp_cnt = st_q.amp_cnt + 13'h0001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q      <= '0;
            st_q.ovuv <= 1'b1; // R3
            st_q.ctrl <= gdc_pkg::CTRL_RST;
            st_q.amp  <= gdc_pkg::AMP_RST; // R10
            st_q.tim  <= gdc_pkg::TIME_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign awready = !st_q.aw_got;
    assign wready  = !st_q.w_got;
    assign bvalid  = st_q.bvalid;
    assign bresp   = st_q.bresp;
    assign arready = !st_q.rvalid;
    assign rvalid  = st_q.rvalid;
    assign rdata   = st_q.rdata;
    assign rresp   = st_q.rresp;

    // the disable pin gates the hi and lo gate outputs directly; pd_hi and pd_lo are not gated
    assign gate.hi    = ph_hi & {3{!hardware_disable_in}}; // R13
    assign gate.lo    = ph_lo & {3{!hardware_disable_in}}; // R13
    assign gate.pd_hi = ph_pdh;
    assign gate.pd_lo = ph_pdl;
    assign bootstrap_charge_en = st_q.ctrl[gdc_pkg::TCP_BIT] ? 3'b111 : ~lo_s; // R1 R2
    assign semi_pd_low  = {3{st_q.s2[9] | (st_q.sd == gdc_pkg::SD_SEMI)}}; // R18 R14
    assign semi_pd_high = st_q.sd == gdc_pkg::SD_SEMI; // R14
    assign shutdown_stage        = st_q.sd;
    assign shutdown_sink_current = st_q.tim[gdc_pkg::SDI_LSB +: 4];
    assign charge_pump_en        = !st_q.uv; // R16
    assign gate_supply_softstart_disable = st_q.ctrl[gdc_pkg::SS_BIT];
    assign current_sense_amp     = st_q.amp;
    assign amp_ready             = st_q.amp_rdy;
    assign fault_out_n = !(st_q.ovuv | st_q.stp | st_q.uv
                           | (st_q.uvw & st_q.ctrl[gdc_pkg::WARN_BIT])); // R15 R16 R20

    localparam int SD1_A = gdc_pkg::SD1_CYC;
    localparam int SD2_A = gdc_pkg::SD2_CYC;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence sd_enter;
        st_q.sd == gdc_pkg::SD_RUN ##1 st_q.sd == gdc_pkg::SD_INIT;
    endsequence
    sequence sd_stages;
        ##SD1_A st_q.sd == gdc_pkg::SD_PROG ##SD2_A st_q.sd == gdc_pkg::SD_SEMI;
    endsequence

    a_sd_sequence: assert property (sd_enter |-> sd_stages) // R14
        else $error("shutdown stages out of order or time");
    a_pin_bypass: assert property (hardware_disable_in |-> gate.hi == 3'b000 // R13
        && gate.lo == 3'b000)
        else $error("gate on while disable pin high");
    // phase flops lag the lockout flag by one edge
    a_uv_lockout: assert property (st_q.uv |-> !charge_pump_en && !fault_out_n // R16
        ##1 gate.hi == 3'b000 && gate.lo == 3'b000)
        else $error("lockout without disable");
    a_uv_latched: assert property (st_q.uv && !clr |=> st_q.uv) // R17
        else $error("lockout flag lost without clear");
    a_ovuv_power_up: assert property (!$past(aresetn) |-> st_q.ovuv && !st_q.amp.en) // R3
        else $error("power-up flag or amplifier state wrong");
    a_trickle_gate: assert property (!st_q.ctrl[gdc_pkg::TCP_BIT] |-> // R1
        bootstrap_charge_en == ~lo_s)
        else $error("bootstrap charge ignores low input");
    a_fault_shut: assert property (shut && st_q.sd == gdc_pkg::SD_RUN |=> // R12
        st_q.sd == gdc_pkg::SD_INIT)
        else $error("fault did not start shutdown");
endmodule

/* File: tb/pwm_host.sv */
`timescale 1ns/1ns
module pwm_host
#(
    parameter int SETTLE = 20
)
(
    // clock
    input  wire logic       aclk,
    // wanted pin levels and amplifier state
    input  wire logic [2:0] want_hi,
    input  wire logic [2:0] want_lo,
    input  wire logic       amp_on,
    // pins and sampling permit
    output logic [2:0]      high_side_pwm_in,
    output logic [2:0]      low_side_pwm_in,
    output logic            may_sample
);
    int cnt = 0;

    initial {high_side_pwm_in, low_side_pwm_in, may_sample} = '0;

    // pins follow the wanted levels; a clash only when the bench asks for one
    always @(posedge aclk)
    begin
        high_side_pwm_in <= want_hi;
        low_side_pwm_in  <= want_lo;
        cnt              <= amp_on ? cnt + 1 : 0;
        may_sample       <= amp_on && cnt >= SETTLE;
    end
endmodule

/* File: tb/gate_drive_control_protection_test.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module gate_drive_control_protection_test;
    logic               aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic               arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0]         awaddr = '0, araddr = '0;
    logic [31:0]        wdata = '0, rdata, rd;
    logic [3:0]         wstrb = 4'hf, shutdown_sink_current;
    logic [1:0]         bresp, rresp, rs;
    logic [2:0]         high_side_pwm_in, low_side_pwm_in, want_hi = '0, want_lo = '0;
    logic               hardware_disable_in = 0, supply_below_warn = 0;
    logic               supply_below_lockout = 0, sleep_in = 0, may_sample;
    logic [2:0]         bootstrap_charge_en, semi_pd_low;
    logic               semi_pd_high, charge_pump_en, gate_supply_softstart_disable;
    logic               amp_ready, fault_out_n;
    gdc_pkg::gate_bus_t gate;
    gdc_pkg::sd_state_t shutdown_stage;
    gdc_pkg::amp_cfg_t  current_sense_amp;
    int                 mismatches = 0, n_checks = 0, n, g, gp, pd, r;
    int                 exp_reg [3] = '{32'h10, 0, 32'h50a};
    int                 dt_cfg [4] = '{32'h10, 32'h14, 32'h00, 32'h02};
    logic               dt_ins [4] = '{1, 0, 1, 1};

    gate_drive_ctrl #(.AMP_SETTLE_CYC(20)) dut_u
    (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .high_side_pwm_in, .low_side_pwm_in, .hardware_disable_in,
        .supply_below_warn, .supply_below_lockout, .sleep_in, .gate, .bootstrap_charge_en,
        .semi_pd_low, .semi_pd_high, .shutdown_stage, .shutdown_sink_current,
        .charge_pump_en, .gate_supply_softstart_disable, .current_sense_amp, .amp_ready,
        .fault_out_n
    );

    pwm_host #(.SETTLE(20)) host_u
    (
        .aclk, .want_hi, .want_lo, .amp_on(current_sense_amp.en), .high_side_pwm_in,
        .low_side_pwm_in, .may_sample
    );

    initial forever #10 aclk = ~aclk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic hung(input int k);
        if (k >= 2000)
        begin
            mismatches++;
            stop_test();
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        n = 0;
        do
        begin
            @(negedge aclk);
            {ta, tw, tb, rs} = {awready, wready, bvalid, bresp};
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            n++;
        end
        while (!tb && n < 2000);
        bready <= 0;
        hung(n);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        logic ta, tv;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        n = 0;
        do
        begin
            @(negedge aclk);
            {ta, tv, rd, rs} = {arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (ta) arvalid <= 0;
            n++;
        end
        while (!tv && n < 2000);
        rready <= 0;
        hung(n);
    endtask

    task automatic wreg(input int i, input int d);
        exp_reg[i] = d;
        wr(8'(i * 4), 32'(d));
    endtask

    task automatic until_st(input gdc_pkg::sd_state_t s);
        n = 0;
        while (shutdown_stage !== s && n < 2000)
        begin
            @(negedge aclk);
            n++;
        end
        hung(n);
    endtask

    task automatic len_st(input gdc_pkg::sd_state_t s, output int c);
        c = 0;
        while (shutdown_stage === s && c < 2000)
        begin
            @(negedge aclk);
            c++;
        end
    endtask

    // low gate on, then swap to high at once; gap and opposite pull-down measured
    task automatic gap;
        @(posedge aclk);
        want_lo <= 3'b001;
        cyc(20);
        @(posedge aclk);
        {want_lo, want_hi} <= 6'b000001;
        for (pd = 0; gate.lo[0] === 1'b1 && pd < 50; pd++) @(negedge aclk);
        `CHK(gate.pd_hi[0], 1'b1)
        for (gp = 0; gate.hi[0] !== 1'b1 && gp < 50; gp++) @(negedge aclk);
        pd = 0;
        repeat (40)
        begin
            pd += int'(gate.pd_lo[0] === 1'b1);
            @(negedge aclk);
        end
        @(posedge aclk);
        want_hi <= '0;
        cyc(40);
    endtask

    initial
    begin
        void'($urandom(67));
        cyc(10);
        @(posedge aclk);
        aresetn <= 1;
        cyc(2);
        `CHK(fault_out_n, 1'b0)
        for (int i = 0; i < 3; i++)
        begin
            rd_reg(8'(i * 4));
            `CHK(rd, 32'(exp_reg[i]))
        end
        rd_reg(8'h0c);
        `CHK(rd[gdc_pkg::ST_OVUV], 1'b1)
        rd_reg(8'h20);
        `CHK({rs, rd}, {2'b10, 32'h0})
        wr(8'h20, 32'h0);
        `CHK(rs, 2'b10)
        wr(8'h10, 32'h1);
        until_st(gdc_pkg::SD_RUN);
        `CHK(fault_out_n, 1'b1)
        wreg(0, 32'h30);
        `CHK(gate_supply_softstart_disable, 1'b1)
        g = $urandom_range(20, 3);
        wreg(2, ($urandom_range(15, 0) << 16) | 32'h500 | g);
        `CHK(shutdown_sink_current, exp_reg[2][19:16])
        foreach (dt_cfg[i])
        begin
            wreg(0, dt_cfg[i]);
            gap();
            `CHK(gp >= 5, dt_ins[i])
            `CHK(pd, g)
        end
        wreg(0, 32'h10);
        @(posedge aclk);
        {want_hi, want_lo} <= 6'b010010;
        cyc(8);
        `CHK({gate.hi[1], gate.lo[1], fault_out_n}, 3'b000)
        @(posedge aclk);
        {want_hi, want_lo} <= '0;
        rd_reg(8'h0c);
        `CHK({rd[gdc_pkg::ST_STP], fault_out_n}, 2'b10)
        wr(8'h10, 32'h1);
        cyc(2);
        `CHK(fault_out_n, 1'b1)
        @(posedge aclk);
        want_hi <= 3'b100;
        cyc(12);
        `CHK(gate.hi[2], 1'b1)
        @(posedge aclk);
        hardware_disable_in <= 1;
        #1;
        `CHK(gate.hi[2], 1'b0)
        until_st(gdc_pkg::SD_INIT);
        len_st(gdc_pkg::SD_INIT, r);
        `CHK(r, gdc_pkg::SD1_CYC)
        len_st(gdc_pkg::SD_PROG, r);
        `CHK(r, gdc_pkg::SD2_CYC)
        `CHK({shutdown_stage, semi_pd_high, semi_pd_low}, {gdc_pkg::SD_SEMI, 4'hf})
        @(posedge aclk);
        {hardware_disable_in, want_hi} <= '0;
        until_st(gdc_pkg::SD_RUN);
        for (int m = 0; m < 3; m++)
        begin
            wreg(0, m == 1 ? 32'h50 : 32'h10);
            @(posedge aclk);
            {supply_below_warn, supply_below_lockout} <= m == 2 ? 2'b01 : 2'b10;
            cyc(60);
            `CHK(fault_out_n, 1'b1)
            cyc(60);
            `CHK({fault_out_n, charge_pump_en}, m == 0 ? 2'b11 : m == 1 ? 2'b01 : 2'b00)
            @(posedge aclk);
            {supply_below_warn, supply_below_lockout} <= '0;
            cyc(20);
            rd_reg(8'h0c);
            `CHK(rd[3:2], m == 2 ? 2'b10 : 2'b01)
            wr(8'h10, 32'h1);
            until_st(gdc_pkg::SD_RUN);
            `CHK(fault_out_n, 1'b1)
        end
        @(posedge aclk);
        sleep_in <= 1;
        cyc(5);
        `CHK(semi_pd_low, 3'b111)
        @(posedge aclk);
        {sleep_in, want_lo} <= 4'h5;
        cyc(5);
        `CHK(bootstrap_charge_en, 3'b010)
        wreg(0, 32'h11);
        cyc(2);
        `CHK(bootstrap_charge_en, 3'b111)
        `CHK(current_sense_amp.en, 1'b0)
        for (int c = 0; c < 10; c++)
        begin
            r = $urandom_range(1, 0);
            exp_reg[1] = (r << 5) | ((c > 8 ? 8 : c) << 1) | 1;
            wr(8'h04, 32'((r << 5) | (c << 1) | 1));
            rd_reg(8'h04);
            `CHK(rd, 32'(exp_reg[1]))
            `CHK(current_sense_amp.half_ref, 1'(r))
            `CHK(current_sense_amp.gain, 4'(c > 8 ? 8 : c))
        end
        for (n = 0; !may_sample && n < 2000; n++) @(negedge aclk);
        hung(n);
        `CHK(amp_ready, 1'b1)
        stop_test();
    end
endmodule
